// ---- rtl/byte_latch.v ----
// Holding latch for the first byte of a word coming off the narrow bus.
`timescale 1ns/1ps
`include "funnel_map.vh"

module byte_latch #(
  parameter WIDTH = `FUNNEL_BYTE_W
) (
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] data_o
);

  // The stored byte is read out of a register, never passed through.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= {WIDTH{1'b0}};
    end else if (load_i) begin
      data_o <= data_i;
    end
  end

endmodule // byte_latch

// ---- rtl/word_to_byte_data_funnel.v ----
// Funnel between a 16-bit bus-master peripheral and an 8-bit system bus.
//
// What this block, the peripheral and the CPU must do
// RQ1: Peripheral word goes out low byte, then high.
// RQ2: Latch first fetched byte, then present whole word.
// RQ3: No CPU slave access during master transaction.
// RQ4: No mastership grant inside a slave access.
// RQ5: Withhold acknowledge so peripheral waits two cycles.
// RQ6: Master read: wait held until second byte ends.
// RQ7: Peripheral keeps word valid across both cycles.
// RQ8: Only first byte latched; second goes straight through.
// RQ9: CPU writes latched byte first, other second.
// RQ10: CPU locks bus or disables arbitration meanwhile.
// RQ11: Separate master read, slave read, slave write flows.
// RQ12: Own byte select in master, system's in slave.
// RQ13: Peripheral strobes pulse once per word; per_slave_rd_o is held high for the whole slave read.
// RQ14: Reset gives idle, no wait, drivers off.
`timescale 1ns/1ps
`include "funnel_map.vh"

module word_to_byte_data_funnel #(
  parameter BYTE_W = `FUNNEL_BYTE_W
) (
  input  wire              clk_i,
  input  wire              rstn_i,
  // Peripheral side
  input  wire              per_hold_req_i,
  output reg               per_hold_ack_o,
  input  wire              per_strobe_i,
  input  wire              per_write_i,
  input  wire [2*BYTE_W-1:0] per_data_i,
  output reg  [2*BYTE_W-1:0] per_data_o,
  output reg               per_data_oe_n_o,
  output reg               per_wait_o,
  output reg               per_load_o,
  output reg               per_slave_rd_o,
  output reg               per_slave_wr_o,
  // System side
  input  wire              sys_cs_i,
  input  wire              sys_rd_i,
  input  wire              sys_wr_i,
  input  wire              byte_select_address_bit_i,
  input  wire              sys_ack_i,
  input  wire [BYTE_W-1:0] sys_data_i,
  output reg  [BYTE_W-1:0] sys_data_o,
  output reg               sys_data_oe_n_o,
  output reg               sys_rd_o,
  output reg               sys_wr_o,
  output reg               byte_select_address_bit_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [`FUNNEL_STATE_W-1:0] ST_IDLE  = 3'h0;
  localparam [`FUNNEL_STATE_W-1:0] ST_MLOW  = 3'h1;
  localparam [`FUNNEL_STATE_W-1:0] ST_MGAP  = 3'h2;
  localparam [`FUNNEL_STATE_W-1:0] ST_MHIGH = 3'h3;
  localparam [`FUNNEL_STATE_W-1:0] ST_SRLOW = 3'h4;
  localparam [`FUNNEL_STATE_W-1:0] ST_SRHI  = 3'h5;
  localparam [`FUNNEL_STATE_W-1:0] ST_SWLOW = 3'h6;

  reg [`FUNNEL_STATE_W-1:0] state;
  reg                       master_wr;
  reg                       latch_load;
  reg  [BYTE_W-1:0]         latch_in;
  wire [BYTE_W-1:0]         latched_byte;

  wire slave_rd = sys_cs_i & sys_rd_i;
  wire slave_wr = sys_cs_i & sys_wr_i;
  wire first_sel  = (byte_select_address_bit_i == `FUNNEL_SEL_FIRST);
  wire second_sel = (byte_select_address_bit_i == `FUNNEL_SEL_SECOND);

  // ----------------------------------------------------------------
  // First-byte latch
  // ----------------------------------------------------------------
  always @* begin
    latch_load = 1'b0;
    latch_in   = sys_data_i;
    case (state)
      ST_IDLE: begin
        latch_load = ~per_hold_ack_o & slave_wr & first_sel; // RQ8
      end
      ST_MLOW: begin
        latch_load = ~master_wr & sys_ack_i; // RQ2
      end
      default: begin
        latch_load = 1'b0;
      end
    endcase
  end

  byte_latch #(
    .WIDTH (BYTE_W)
  ) u_first_byte (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .load_i (latch_load),
    .data_i (latch_in),
    .data_o (latched_byte)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state                     <= ST_IDLE; // RQ14
      master_wr                 <= 1'b0;
      per_hold_ack_o            <= 1'b0;
      per_data_o                <= `FUNNEL_WORD_RST;
      per_data_oe_n_o           <= `FUNNEL_OE_OFF; // RQ14
      per_wait_o                <= 1'b0; // RQ14
      per_load_o                <= 1'b0;
      per_slave_rd_o            <= 1'b0;
      per_slave_wr_o            <= 1'b0;
      sys_data_o                <= `FUNNEL_BYTE_RST;
      sys_data_oe_n_o           <= `FUNNEL_OE_OFF; // RQ14
      sys_rd_o                  <= 1'b0;
      sys_wr_o                  <= 1'b0;
      byte_select_address_bit_o <= `FUNNEL_SEL_FIRST;
    end else begin
      per_load_o      <= 1'b0;
      per_slave_wr_o  <= 1'b0;
      per_data_oe_n_o <= `FUNNEL_OE_OFF;
      case (state)
        ST_IDLE: begin
          sys_data_oe_n_o <= `FUNNEL_OE_OFF;
          per_slave_rd_o  <= 1'b0;
          if (per_hold_ack_o) begin
            // A new master cycle waits for the last acknowledge to clear.
            if (per_strobe_i & ~sys_ack_i) begin
              master_wr                 <= per_write_i;
              per_wait_o                <= 1'b1; // RQ5
              byte_select_address_bit_o <= `FUNNEL_SEL_FIRST; // RQ12
              sys_rd_o                  <= ~per_write_i;
              sys_wr_o                  <= per_write_i;
              sys_data_o                <= per_data_i[BYTE_W-1:0]; // RQ1
              sys_data_oe_n_o           <= per_write_i ? `FUNNEL_OE_ON : `FUNNEL_OE_OFF;
              state                     <= ST_MLOW;
            end else if (~per_hold_req_i) begin
              per_hold_ack_o <= 1'b0;
            end
          end else if (slave_rd & first_sel) begin
            per_slave_rd_o  <= 1'b1; // RQ13
            sys_data_o      <= per_data_i[BYTE_W-1:0]; // RQ1
            sys_data_oe_n_o <= `FUNNEL_OE_ON;
            state           <= ST_SRLOW;
          end else if (slave_wr & first_sel) begin
            state <= ST_SWLOW; // RQ11
          end else begin
            per_hold_ack_o <= per_hold_req_i; // RQ4
          end
        end
        ST_MLOW: begin
          // CPU slave strobes are not looked at in any master state.
          if (sys_ack_i) begin // RQ3
            sys_rd_o        <= 1'b0;
            sys_wr_o        <= 1'b0;
            sys_data_oe_n_o <= `FUNNEL_OE_OFF;
            state           <= ST_MGAP;
          end
        end
        ST_MGAP: begin
          if (~sys_ack_i) begin
            byte_select_address_bit_o <= `FUNNEL_SEL_SECOND; // RQ12
            sys_rd_o                  <= ~master_wr;
            sys_wr_o                  <= master_wr;
            sys_data_o                <= per_data_i[2*BYTE_W-1:BYTE_W]; // RQ1
            sys_data_oe_n_o           <= master_wr ? `FUNNEL_OE_ON : `FUNNEL_OE_OFF;
            state                     <= ST_MHIGH;
          end
        end
        ST_MHIGH: begin
          if (sys_ack_i) begin
            sys_rd_o                  <= 1'b0;
            sys_wr_o                  <= 1'b0;
            sys_data_oe_n_o           <= `FUNNEL_OE_OFF;
            byte_select_address_bit_o <= `FUNNEL_SEL_FIRST;
            per_wait_o                <= 1'b0; // RQ6
            if (~master_wr) begin
              per_data_o      <= {sys_data_i, latched_byte}; // RQ2
              per_data_oe_n_o <= `FUNNEL_OE_ON;
              per_load_o      <= 1'b1; // RQ13
            end
            state <= ST_IDLE;
          end
        end
        ST_SRLOW: begin
          sys_data_o <= per_data_i[BYTE_W-1:0];
          if (slave_rd & second_sel) begin
            sys_data_o <= per_data_i[2*BYTE_W-1:BYTE_W]; // RQ1
            state      <= ST_SRHI;
          end
        end
        ST_SRHI: begin
          per_slave_rd_o  <= 1'b0;
          sys_data_oe_n_o <= `FUNNEL_OE_OFF;
          state           <= ST_IDLE;
        end
        ST_SWLOW: begin
          if (slave_wr & second_sel) begin
            per_data_o      <= {sys_data_i, latched_byte}; // RQ8
            per_data_oe_n_o <= `FUNNEL_OE_ON;
            per_slave_wr_o  <= 1'b1; // RQ13
            state           <= ST_IDLE;
          end else if (slave_wr & first_sel) begin
            state <= ST_SWLOW;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // word_to_byte_data_funnel

// ---- shared/funnel_map.vh ----
// Constants shared by the word-to-byte data funnel design files.
`ifndef FUNNEL_MAP_VH
`define FUNNEL_MAP_VH

// ----------------------------------------------------------------
// Data path widths
// ----------------------------------------------------------------
`define FUNNEL_BYTE_W     8
`define FUNNEL_WORD_W     16

// ----------------------------------------------------------------
// Byte order on the narrow bus (lower byte first, lower byte latched)
// ----------------------------------------------------------------
`define FUNNEL_SEL_FIRST  1'b0
`define FUNNEL_SEL_SECOND 1'b1

// ----------------------------------------------------------------
// Output enable levels (active low), state width and reset values
// ----------------------------------------------------------------
`define FUNNEL_OE_ON      1'b0
`define FUNNEL_OE_OFF     1'b1
`define FUNNEL_STATE_W    3
`define FUNNEL_BYTE_RST   8'h00
`define FUNNEL_WORD_RST   16'h0000

`endif

// ---- sim/funnel_monitor.sv ----
// Port-level checker for the word-to-byte data funnel.
`timescale 1ns/1ps
module funnel_monitor (
  input wire        clk_i,
  input wire        rstn_i,
  input wire        per_hold_ack_o,
  input wire [15:0] per_data_o,
  input wire        per_data_oe_n_o,
  input wire        per_wait_o,
  input wire        per_load_o,
  input wire        per_slave_rd_o,
  input wire        per_slave_wr_o,
  input wire [7:0]  sys_data_i,
  input wire        sys_data_oe_n_o,
  input wire        byte_select_address_bit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_first_low: assert property (
    $rose(per_wait_o) |-> !byte_select_address_bit_o) else $error("first byte not low");
  a_last_high: assert property (
    $fell(per_wait_o) |-> $past(byte_select_address_bit_o)) else $error("last byte not high");
  a_wait_stretch: assert property (
    $rose(per_wait_o) |-> per_wait_o [*3]) else $error("wait too short");
  a_load_after_wait: assert property (
    per_load_o |-> !per_wait_o && $past(per_wait_o)) else $error("load not at wait end");
  a_load_word: assert property (
    per_load_o |-> !per_data_oe_n_o && per_data_o[15:8] == $past(sys_data_i))
    else $error("loaded word wrong");
  a_no_slave_granted: assert property (
    per_hold_ack_o |-> !per_slave_rd_o && !per_slave_wr_o) else $error("slave while granted");
  a_slave_rd_drive: assert property (
    $rose(per_slave_rd_o) |-> !sys_data_oe_n_o) else $error("slave read not driven");
  a_pulse_once: assert property (
    (per_load_o || per_slave_wr_o) |=> !per_load_o && !per_slave_wr_o) else $error("long pulse");
  c_load: cover property (per_load_o);
  c_slave_wr: cover property (per_slave_wr_o);
  c_slave_rd: cover property ($rose(per_slave_rd_o));
endmodule // funnel_monitor

// ---- sim/sys_mem_model.sv ----
// Byte-wide system memory that answers the funnel's master byte cycles.
`timescale 1ns/1ps
module sys_mem_model #(
  parameter [15:0] WORD = 16'hc35a
) (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        rd_i,
  input  wire        wr_i,
  input  wire        sel_i,
  input  wire [7:0]  wdata_i,
  input  wire [3:0]  lat_i,
  output reg         ack_o,
  output reg  [7:0]  rdata_o,
  output reg  [15:0] wword_o
);
  reg [3:0] cnt;
  // Read data is valid only in the acknowledge cycle; otherwise it toggles.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 4'h0;
      ack_o <= 1'h0;
      rdata_o <= 8'h00;
      wword_o <= 16'h0000;
    end else begin
      ack_o <= 1'h0;
      rdata_o <= ~rdata_o;
      cnt <= 4'h0;
      if ((rd_i || wr_i) && !ack_o && cnt == lat_i) begin
        ack_o <= 1'h1;
        rdata_o <= sel_i ? WORD[15:8] : WORD[7:0];
        if (wr_i && sel_i) wword_o[15:8] <= wdata_i;
        if (wr_i && !sel_i) wword_o[7:0] <= wdata_i;
      end else if ((rd_i || wr_i) && !ack_o) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // sys_mem_model

// ---- sim/tb.sv ----
// Self-checking bench for the word-to-byte data funnel.
`timescale 1ns/1ps
module tb;
  logic clk_i, rstn_i, per_hold_req_i, per_strobe_i, per_write_i, sys_cs_i, sys_rd_i;
  logic sys_wr_i, byte_select_address_bit_i, sys_ack_i, per_hold_ack_o, per_data_oe_n_o;
  logic per_wait_o, per_load_o, per_slave_rd_o, per_slave_wr_o, sys_data_oe_n_o, sys_rd_o;
  logic sys_wr_o, byte_select_address_bit_o;
  logic [15:0] per_data_i, per_data_o, wword;
  logic [7:0]  sys_data_i, sys_data_o, cpu_data, mem_data;
  logic [3:0]  lat;
  int          miscompares, checks;
  assign sys_data_i = per_hold_ack_o ? mem_data : cpu_data;
  word_to_byte_data_funnel word_to_byte_data_funnel_inst (
    .clk_i                     (clk_i),
    .rstn_i                    (rstn_i),
    .per_hold_req_i            (per_hold_req_i),
    .per_hold_ack_o            (per_hold_ack_o),
    .per_strobe_i              (per_strobe_i),
    .per_write_i               (per_write_i),
    .per_data_i                (per_data_i),
    .per_data_o                (per_data_o),
    .per_data_oe_n_o           (per_data_oe_n_o),
    .per_wait_o                (per_wait_o),
    .per_load_o                (per_load_o),
    .per_slave_rd_o            (per_slave_rd_o),
    .per_slave_wr_o            (per_slave_wr_o),
    .sys_cs_i                  (sys_cs_i),
    .sys_rd_i                  (sys_rd_i),
    .sys_wr_i                  (sys_wr_i),
    .byte_select_address_bit_i (byte_select_address_bit_i),
    .sys_ack_i                 (sys_ack_i),
    .sys_data_i                (sys_data_i),
    .sys_data_o                (sys_data_o),
    .sys_data_oe_n_o           (sys_data_oe_n_o),
    .sys_rd_o                  (sys_rd_o),
    .sys_wr_o                  (sys_wr_o),
    .byte_select_address_bit_o (byte_select_address_bit_o)
  );
  sys_mem_model sys_mem_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(sys_rd_o), .wr_i(sys_wr_o),
    .sel_i(byte_select_address_bit_o), .wdata_i(sys_data_o), .lat_i(lat), .ack_o(sys_ack_i),
    .rdata_o(mem_data), .wword_o(wword));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_i);
    #2;
  endtask
  task automatic bound(input int i);
    if (i >= 40) begin
      miscompares++;
      give_verdict;
    end
  endtask
  // Code is {cs, rd, wr, byte select}; one CPU byte access per call.
  task automatic acc(input logic [3:0] c, input logic [7:0] d);
    {sys_cs_i, sys_rd_i, sys_wr_i, byte_select_address_bit_i} = c;
    cpu_data = d;
    tick;
  endtask
  // Master word transfer; the CPU keeps trying slave reads all along.
  task automatic master(input logic wr, input logic [3:0] l);
    int i;
    lat = l;
    per_write_i = wr;
    per_hold_req_i = 1'h1;
    for (i = 0; i < 40 && per_hold_ack_o !== 1'h1; i++) tick;
    bound(i);
    per_strobe_i = 1'h1;
    acc(4'hc, 8'h00);
    per_strobe_i = 1'h0;
    for (i = 0; i < 40 && per_wait_o === 1'h1; i++) begin
      check(per_slave_rd_o, 1'h0);
      if (i == 0)
        check({sys_rd_o, sys_wr_o, byte_select_address_bit_o}, {!wr, wr, 1'h0});
      tick;
    end
    bound(i);
    // The memory acknowledges one cycle after it sees a strobe, so each byte takes
    // two cycles plus its latency, and the gap between the bytes one more.
    check(18'(i), 18'(5 + 2 * l));
    check({sys_rd_o, sys_wr_o, byte_select_address_bit_o}, 3'h0);
    check(per_load_o, !wr);
    check(wr ? wword : per_data_o, wr ? per_data_i : 16'hc35a);
    per_hold_req_i = 1'h0;
    acc(4'h0, 8'h00);
    check(per_load_o, 1'h0);
    tick;
    tick;
  endtask
  task automatic slave_read;
    per_hold_req_i = 1'h1;
    acc(4'hc, 8'h00);
    check({per_slave_rd_o, sys_data_oe_n_o, per_hold_ack_o, sys_data_o},
          {3'h4, per_data_i[7:0]});
    acc(4'h0, 8'h00);
    acc(4'hd, 8'h00);
    check({per_hold_ack_o, sys_data_o}, {1'h0, per_data_i[15:8]});
    per_hold_req_i = 1'h0;
    acc(4'h0, 8'h00);
    check({per_slave_rd_o, sys_data_oe_n_o}, 2'h1);
  endtask
  task automatic slave_write;
    acc(4'hb, 8'h99);
    check(per_slave_wr_o, 1'h0);
    acc(4'ha, 8'h77);
    acc(4'ha, 8'h19);
    acc(4'hb, 8'he4);
    // A repeated low-byte write does not replace the byte already latched.
    check({per_slave_wr_o, per_data_oe_n_o, per_data_o}, {2'h2, 16'he477});
    acc(4'h0, 8'h00);
    check(per_slave_wr_o, 1'h0);
  endtask
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {per_hold_req_i, per_strobe_i, per_write_i, sys_cs_i, sys_rd_i, sys_wr_i} = 6'h00;
    byte_select_address_bit_i = 1'h0;
    cpu_data = 8'h00;
    lat = 4'h0;
    rstn_i = 1'h0;
    per_data_i = 16'hbe71;
    repeat (6) @(posedge clk_i);
    #2;
    check({per_hold_ack_o, per_wait_o, per_data_oe_n_o, sys_data_oe_n_o, sys_rd_o},
          5'h06);
    rstn_i = 1'h1;
    master(1'h0, 4'h0);
    master(1'h0, 4'h3);
    master(1'h1, 4'h0);
    master(1'h1, 4'h2);
    slave_read;
    slave_write;
    give_verdict;
  end
endmodule // tb
bind word_to_byte_data_funnel funnel_monitor funnel_monitor_inst (
  .clk_i                     (clk_i),
  .rstn_i                    (rstn_i),
  .per_hold_ack_o            (per_hold_ack_o),
  .per_data_o                (per_data_o),
  .per_data_oe_n_o           (per_data_oe_n_o),
  .per_wait_o                (per_wait_o),
  .per_load_o                (per_load_o),
  .per_slave_rd_o            (per_slave_rd_o),
  .per_slave_wr_o            (per_slave_wr_o),
  .sys_data_i                (sys_data_i),
  .sys_data_oe_n_o           (sys_data_oe_n_o),
  .byte_select_address_bit_o (byte_select_address_bit_o)
);
